/* src/tcnt_edge_detect.sv */
// Purpose: rising-edge detector for the external count input
// Assumes: input already sampled level-wise relative to pclk
// Notes: sync path uses two synchroniser stages and a history stage; bypass path a single stage
`timescale 1ns/1ns
module tcnt_edge_detect
  import tcnt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic raw_in,
  input wire logic bypass,
  output logic rise
);

  logic meta_r;
  logic sync_r;
  logic sync_d_r;
  logic raw_d_r;

  // two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      sync_d_r <= 1'b0;
    end else begin
      meta_r <= raw_in;
      sync_r <= meta_r;
      sync_d_r <= sync_r;
    end
  end

  // single history stage for the unsynchronised path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_d_r <= 1'b0;
    end else begin
      raw_d_r <= raw_in;
    end
  end

  // edge select
  assign rise = bypass ? (raw_in & ~raw_d_r) : (sync_r & ~sync_d_r);

endmodule

/* src/tcnt_pkg.sv */
// Purpose: shared constants for the 16-bit timer/counter block
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes: register offsets are byte addresses
package tcnt_pkg;

  // register byte offsets
  localparam logic [7:0] TCNT_OFS_CONTROL = 8'h00;
  localparam logic [7:0] TCNT_OFS_LOW = 8'h04;
  localparam logic [7:0] TCNT_OFS_HIGH = 8'h08;
  localparam logic [7:0] TCNT_OFS_FLAG = 8'h0c;
  localparam logic [7:0] TCNT_OFS_OSC = 8'h10;

  // timer_control field positions
  localparam int TCNT_B_RUN = 0;
  localparam int TCNT_B_SRC = 1;
  localparam int TCNT_B_SYNC = 2;
  localparam int TCNT_B_OSCEN = 3;
  localparam int TCNT_B_PS_LO = 4;
  localparam int TCNT_B_PS_HI = 5;
  localparam int TCNT_B_STAT = 6;
  localparam int TCNT_B_WIDE = 7;

  // peripheral_flag_reg and oscillator_control fields
  localparam int TCNT_B_OVF = 0;
  localparam int TCNT_B_OVF_IE = 1;
  localparam int TCNT_B_SCS_LO = 0;
  localparam int TCNT_B_SCS_HI = 1;
  localparam int TCNT_B_IDLE_ON_SLEEP_ENABLE = 7;

  // reset values and count maximum
  localparam logic [7:0] TCNT_RST_CONTROL = 8'h00;
  localparam logic [7:0] TCNT_RST_BYTE = 8'h00;
  localparam logic [15:0] TCNT_RST_COUNT = 16'h0000;
  localparam logic [15:0] TCNT_COUNT_MAX = 16'hffff;
  localparam logic [1:0] TCNT_RST_SCS = 2'h0;

  // encodings
  localparam logic [1:0] TCNT_SCS_TIMER_OSC = 2'h1;
  localparam logic [3:0] TCNT_CMP_SPECIAL_EVENT = 4'hb;
  localparam logic [1:0] TCNT_PS_1 = 2'h0;
  localparam logic [1:0] TCNT_PS_2 = 2'h1;
  localparam logic [1:0] TCNT_PS_4 = 2'h2;
  localparam logic [1:0] TCNT_PS_8 = 2'h3;

  // instruction clock is the system clock divided by four
  localparam int TCNT_INSTR_DIV = 4;
  localparam logic [1:0] TCNT_INSTR_LAST = 2'(TCNT_INSTR_DIV - 1);

  // operating mode, derived from source and sync bits
  typedef enum logic [1:0] {
    TCNT_MODE_TIMER = 2'b00,
    TCNT_MODE_SYNC = 2'b01,
    TCNT_MODE_ASYNC = 2'b11
  } tcnt_mode_t;

endpackage

/* src/tcnt_timer.sv */
// Purpose: 16-bit timer/counter with APB register access
// Assumes: pclk is the system oscillator; pins arrive synchronous to it
// Notes: pready is always high; reads are captured in the setup cycle
// Operation
// - internal source counts once per instruction cycle, system clock over four.
// - external source counts rising edges of pin or enabled oscillator.
// - run bit starts counting; clearing it holds the count.
// - prescale field divides input by 1, 2, 4 or 8.
// - sync bit chooses synchronised or bypassed external edge; ignored internally.
// - three modes: timer, synchronous counter, asynchronous counter.
// - oscillator enable bit runs oscillator, independent of power mode.
// - while running, oscillator pins are inputs and port reads give zero.
// - wide access bit selects one 16-bit access or two byte accesses.
// - in wide mode low read copies live high byte to buffer.
// - in wide mode low write loads high from buffer with low.
// - low byte write clears prescaler; high writes leave it alone.
// - status bit reads one while system clock comes from timer oscillator.
// - clock select 01 runs CPU and peripherals from timer oscillator.
// - control register resets to zero.
// - count wraps FFFF to 0000, sets overflow flag, interrupt if enabled.
// - compare trigger in mode 1011 resets count; coincident write wins.
// - trigger reset never sets the overflow flag.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module tcnt_timer
  import tcnt_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PS_W = 3
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clk_in,
  input wire logic osc_clk_in,
  input wire logic [1:0] port_pin_in,
  input wire logic [1:0] port_pin_out_data,
  input wire logic [1:0] port_direction_bits,
  output logic [1:0] port_pin_out,
  output logic [1:0] port_pin_oe_n,
  output logic [1:0] port_read_data,
  output logic timer_osc_enable,
  input wire logic sysclk_is_timer_osc,
  output logic secondary_run_mode,
  output logic idle_on_sleep_enable,
  input wire logic special_event_trigger,
  input wire logic [3:0] compare_mode_field,
  output logic overflow_irq,
  output logic [CNT_W-1:0] count_value
);

  logic [7:0] control_r;
  logic [7:0] high_buf_r;
  logic [CNT_W-1:0] count_r;
  logic [PS_W-1:0] presc_r;
  logic [1:0] instr_r;
  logic ovf_flag_r;
  logic ovf_ie_r;
  logic [1:0] scs_r;
  logic idle_on_sleep_enable_r;
  logic [31:0] prdata_r;
  logic status_r;

  logic setup_rd;
  logic acc_wr;
  logic wr_ctrl;
  logic wr_low;
  logic wr_high;
  logic wr_flag;
  logic wr_osc;
  logic rd_low;
  logic mapped;
  logic run;
  logic wide;
  logic src_ext;
  logic instr_tick;
  logic ext_rise;
  logic in_tick;
  logic presc_tick;
  logic inc;
  logic wrap;
  logic trig;
  tcnt_mode_t mode;

  // prescale ratio as a terminal count mask
  function automatic logic [PS_W-1:0] presc_mask(input logic [1:0] sel);
    case (sel)
      TCNT_PS_1: presc_mask = PS_W'(0);
      TCNT_PS_2: presc_mask = PS_W'(1);
      TCNT_PS_4: presc_mask = PS_W'(3);
      TCNT_PS_8: presc_mask = PS_W'(7);
      default: presc_mask = PS_W'(0);
    endcase
  endfunction

  // address decode, used for both read and write
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction

  // bus decode
  assign setup_rd = psel & ~penable & ~pwrite;
  assign acc_wr = psel & penable & pwrite & pstrb[0];
  assign wr_ctrl = acc_wr & is_reg(paddr, TCNT_OFS_CONTROL);
  assign wr_low = acc_wr & is_reg(paddr, TCNT_OFS_LOW);
  assign wr_high = acc_wr & is_reg(paddr, TCNT_OFS_HIGH);
  assign wr_flag = acc_wr & is_reg(paddr, TCNT_OFS_FLAG);
  assign wr_osc = acc_wr & is_reg(paddr, TCNT_OFS_OSC);
  assign rd_low = setup_rd & is_reg(paddr, TCNT_OFS_LOW);
  assign mapped = is_reg(paddr, TCNT_OFS_CONTROL)
                | is_reg(paddr, TCNT_OFS_LOW)
                | is_reg(paddr, TCNT_OFS_HIGH)
                | is_reg(paddr, TCNT_OFS_FLAG)
                | is_reg(paddr, TCNT_OFS_OSC);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_r;

  // control fields
  assign run = control_r[TCNT_B_RUN];
  assign wide = control_r[TCNT_B_WIDE];
  assign src_ext = control_r[TCNT_B_SRC];

  // mode from source and sync bits
  always_comb begin
    case ({src_ext, control_r[TCNT_B_SYNC]})
      2'b10: mode = TCNT_MODE_SYNC;
      2'b11: mode = TCNT_MODE_ASYNC;
      default: mode = TCNT_MODE_TIMER;
    endcase
  end

  // control register, status bit is read-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_r <= TCNT_RST_CONTROL;
    end else if (wr_ctrl) begin
      control_r <= pwdata[7:0] & ~(8'h01 << TCNT_B_STAT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= 1'b0;
    end else begin
      status_r <= sysclk_is_timer_osc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scs_r <= TCNT_RST_SCS;
      idle_on_sleep_enable_r <= 1'b0;
    end else if (wr_osc) begin
      scs_r <= pwdata[TCNT_B_SCS_HI:TCNT_B_SCS_LO];
      idle_on_sleep_enable_r <= pwdata[TCNT_B_IDLE_ON_SLEEP_ENABLE];
    end
  end
  assign secondary_run_mode = (scs_r == TCNT_SCS_TIMER_OSC);
  assign idle_on_sleep_enable = idle_on_sleep_enable_r;

  // oscillator runs by its enable bit alone
  assign timer_osc_enable = control_r[TCNT_B_OSCEN];

  // pins forced to inputs and reads zeroed while running
  always_comb begin
    port_pin_out = port_pin_out_data;
    if (run) begin
      port_pin_oe_n = 2'b11;
      port_read_data = 2'b00;
    end else begin
      port_pin_oe_n = port_direction_bits;
      port_read_data = port_pin_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_r <= 2'h0;
    end else begin
      instr_r <= instr_r + 2'h1;
    end
  end
  assign instr_tick = (instr_r == TCNT_INSTR_LAST);

  tcnt_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .raw_in(control_r[TCNT_B_OSCEN] ? osc_clk_in : ext_clk_in),
    .bypass(mode == TCNT_MODE_ASYNC),
    .rise(ext_rise)
  );

  assign in_tick = src_ext ? ext_rise : instr_tick;

  // prescaler, cleared by low byte write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= '0;
    end else if (wr_low) begin
      presc_r <= '0;
    end else if (run && in_tick) begin
      if (presc_r >= presc_mask(control_r[TCNT_B_PS_HI:TCNT_B_PS_LO])) begin
        presc_r <= '0;
      end else begin
        presc_r <= presc_r + PS_W'(1);
      end
    end
  end
  assign presc_tick = in_tick
    & (presc_r >= presc_mask(control_r[TCNT_B_PS_HI:TCNT_B_PS_LO]));

  assign inc = run & presc_tick;
  assign wrap = inc & (count_r == TCNT_COUNT_MAX);
  assign trig = special_event_trigger
              & (compare_mode_field == TCNT_CMP_SPECIAL_EVENT);

  // count register; writes take precedence over all else
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= TCNT_RST_COUNT;
    end else if (wr_low) begin
      // wide mode loads high from buffer with low
      if (wide) begin
        count_r <= {high_buf_r, pwdata[7:0]};
      end else begin
        count_r <= {count_r[15:8], pwdata[7:0]};
      end
    end else if (wr_high && !wide) begin
      // byte mode reaches live high directly
      count_r <= {pwdata[7:0], count_r[7:0]};
    end else if (trig) begin
      count_r <= TCNT_RST_COUNT;
    end else if (inc) begin
      count_r <= count_r + 16'h0001;
    end
  end
  assign count_value = count_r;

  // high buffer, loaded on low read in wide mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_buf_r <= TCNT_RST_BYTE;
    end else if (wr_high && wide) begin
      high_buf_r <= pwdata[7:0];
    end else if (rd_low && wide) begin
      high_buf_r <= count_r[15:8];
    end
  end

  // overflow flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag_r <= 1'b0;
      ovf_ie_r <= 1'b0;
    end else begin
      if (wrap && !wr_low && !trig && !(wr_high && !wide)) begin
        ovf_flag_r <= 1'b1;
      end else if (wr_flag && pwdata[TCNT_B_OVF]) begin
        ovf_flag_r <= 1'b0;
      end
      if (wr_flag) begin
        ovf_ie_r <= pwdata[TCNT_B_OVF_IE];
      end
    end
  end

  assign overflow_irq = ovf_flag_r & ovf_ie_r;

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_r <= 32'h0000_0000;
      case (paddr)
        TCNT_OFS_CONTROL: begin
          prdata_r[7:0] <= control_r | ({7'h00, status_r} << TCNT_B_STAT);
        end
        TCNT_OFS_LOW: begin
          prdata_r[7:0] <= count_r[7:0];
        end
        TCNT_OFS_HIGH: begin
          // buffer in wide mode, live high otherwise
          prdata_r[7:0] <= wide ? high_buf_r : count_r[15:8];
        end
        TCNT_OFS_FLAG: begin
          prdata_r[TCNT_B_OVF] <= ovf_flag_r;
          prdata_r[TCNT_B_OVF_IE] <= ovf_ie_r;
        end
        TCNT_OFS_OSC: begin
          prdata_r[TCNT_B_SCS_HI:TCNT_B_SCS_LO] <= scs_r;
          prdata_r[TCNT_B_IDLE_ON_SLEEP_ENABLE] <= idle_on_sleep_enable_r;
        end
        default: begin
          prdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule

/* verification/tcnt_ext_model.sv */
// Purpose: external pin and timer oscillator model
// Assumes: pulses issued just after a pclk edge
// Notes: oscillator stands low while disabled
`timescale 1ns/1ns
module tcnt_ext_model (
  input wire logic pclk,
  input wire logic timer_osc_enable,
  output logic ext_clk_in,
  output logic osc_clk_in
);
  logic [1:0] div_r;
  initial begin
    ext_clk_in = 1'b0;
    osc_clk_in = 1'b0;
    div_r = 2'h0;
  end
  // oscillator toggles every fourth pclk
  always @(posedge pclk) begin
    div_r <= timer_osc_enable ? div_r + 2'h1 : 2'h0;
    if (!timer_osc_enable) osc_clk_in <= 1'b0;
    else if (div_r == 2'h3) osc_clk_in <= ~osc_clk_in;
  end
  // burst of slow edges on the pin
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (3) @(posedge pclk);
      ext_clk_in <= 1'b1;
      repeat (3) @(posedge pclk);
      ext_clk_in <= 1'b0;
    end
  endtask
endmodule

/* verification/tcnt_timer_monitor.sv */
// Purpose: port-level checker for the 16-bit timer/counter
// Assumes: single pclk domain, presetn async active low
// Notes: bound from the testbench top file
`timescale 1ns/1ns
module tcnt_timer_monitor
  import tcnt_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] port_pin_in,
  input wire logic [1:0] port_pin_out_data,
  input wire logic [1:0] port_pin_out,
  input wire logic [1:0] port_pin_oe_n,
  input wire logic [1:0] port_read_data,
  input wire logic secondary_run_mode,
  input wire logic special_event_trigger,
  input wire logic [3:0] compare_mode_field,
  input wire logic overflow_irq,
  input wire logic [CNT_W-1:0] count_value
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write access phase
  wire wr_acc = psel && penable && pwrite;
  // trigger with no competing write
  sequence s_trig;
    special_event_trigger && compare_mode_field == 4'hb && !wr_acc;
  endsequence
  property p_rdy; pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("pslverr outside access");
  property p_pins;
    port_read_data != port_pin_in |-> port_read_data == 2'b00
      && port_pin_oe_n == 2'b11;
  endproperty
  a_pins: assert property (p_pins) else $error("pins not forced");
  property p_out; port_pin_out == port_pin_out_data; endproperty
  a_out: assert property (p_out) else $error("port out mismatch");
  property p_step;
    !$past(wr_acc) && !$past(special_event_trigger)
      && $changed(count_value)
      |-> count_value == CNT_W'($past(count_value) + 1'b1);
  endproperty
  a_step: assert property (p_step) else $error("count jump");
  property p_trig; s_trig |=> count_value == '0; endproperty
  a_trig: assert property (p_trig) else $error("trigger no reset");
  property p_trig_flag; s_trig ##0 !overflow_irq |=> !overflow_irq;
  endproperty
  a_trig_flag: assert property (p_trig_flag) else $error("trig flag");
  property p_ovf;
    $rose(overflow_irq) |-> $past(wr_acc)
      || ($past(count_value) == {CNT_W{1'b1}} && count_value == '0);
  endproperty
  a_ovf: assert property (p_ovf) else $error("irq without wrap");
  property p_sec; $changed(secondary_run_mode) |-> $past(wr_acc);
  endproperty
  a_sec: assert property (p_sec) else $error("mode w/o write");
endmodule

/* verification/testbench.sv */
// Purpose: register-level tests of the timer/counter
// Assumes: pready answers at once but is still awaited
// Notes: expectations follow the register map of the package
`timescale 1ns/1ns
module testbench;
  import tcnt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready;
  logic [7:0] paddr, rv;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, compare_mode_field;
  logic ext_clk_in, osc_clk_in, timer_osc_enable, sysclk_is_timer_osc;
  logic [1:0] port_pin_in, port_pin_out_data, port_direction_bits;
  logic [1:0] port_pin_out, port_pin_oe_n, port_read_data;
  logic secondary_run_mode, idle_on_sleep_enable, special_event_trigger;
  logic overflow_irq, ev;
  logic [15:0] count_value, v;
  int num_errors = 0, check_count = 0, n;
  tcnt_timer u_tcnt_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_in(ext_clk_in), .osc_clk_in(osc_clk_in),
    .port_pin_in(port_pin_in), .port_pin_out_data(port_pin_out_data),
    .port_direction_bits(port_direction_bits),
    .port_pin_out(port_pin_out), .port_pin_oe_n(port_pin_oe_n),
    .port_read_data(port_read_data), .timer_osc_enable(timer_osc_enable),
    .sysclk_is_timer_osc(sysclk_is_timer_osc),
    .secondary_run_mode(secondary_run_mode),
    .idle_on_sleep_enable(idle_on_sleep_enable),
    .special_event_trigger(special_event_trigger),
    .compare_mode_field(compare_mode_field),
    .overflow_irq(overflow_irq), .count_value(count_value));
  tcnt_ext_model u_tcnt_ext_model (.pclk(pclk),
    .timer_osc_enable(timer_osc_enable), .ext_clk_in(ext_clk_in),
    .osc_clk_in(osc_clk_in));
  always #10 pclk = ~pclk;
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata[7:0];
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one more edge so the write is visible to later compares
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      num_errors++;
      $display("BAD %0t: saw %h want %h", $time, s, x);
    end
  endtask
  // cycles until the count next moves
  task automatic wait_chg();
    v = count_value;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (count_value === v && n < 300);
  endtask
  task automatic pulse_trig(input logic [3:0] m);
    compare_mode_field <= m;
    special_event_trigger <= 1'b1;
    @(posedge pclk);
    special_event_trigger <= 1'b0;
    @(posedge pclk);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    $display("BAD %0t: watchdog expired", $time);
    complete_run;
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {special_event_trigger, compare_mode_field, sysclk_is_timer_osc} = '0;
    pstrb = 4'hf;
    port_pin_in = 2'b11;
    port_pin_out_data = 2'b10;
    port_direction_bits = 2'b00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 8'h00);
      chk(rv, 8'h00);
    end
    apb(1'b0, 8'h14, 8'h00);
    chk({rv, ev}, 9'h001);
    chk({port_read_data, port_pin_oe_n, port_pin_out}, 6'h32);
    $display("test reset done");
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, TCNT_OFS_CONTROL, 8'(p << 4) | 8'h01);
      wait_chg();
      wait_chg();
      chk(n, 4 << p);
    end
    chk({port_read_data, port_pin_oe_n}, 4'h3);
    apb(1'b1, TCNT_OFS_CONTROL, 8'h00);
    v = count_value;
    repeat (20) @(posedge pclk);
    chk(count_value, v);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, TCNT_OFS_CONTROL, s ? 8'h07 : 8'h03);
      v = count_value;
      u_tcnt_ext_model.pulses(5);
      repeat (4) @(posedge pclk);
      chk(count_value, v + 16'd5);
    end
    // 1:2 on the pin, low write in mid-ratio restarts the prescaler
    apb(1'b1, TCNT_OFS_CONTROL, 8'h17);
    u_tcnt_ext_model.pulses(1);
    apb(1'b1, TCNT_OFS_LOW, 8'h40);
    u_tcnt_ext_model.pulses(1);
    repeat (4) @(posedge pclk);
    chk(count_value[7:0], 8'h40);
    v = count_value;
    u_tcnt_ext_model.pulses(1);
    repeat (4) @(posedge pclk);
    chk(count_value, v + 16'd1);
    apb(1'b1, TCNT_OFS_CONTROL, 8'h0b);
    // oscillator start-up allowance
    repeat (16) @(posedge pclk);
    v = count_value;
    repeat (64) @(posedge pclk);
    chk({timer_osc_enable, count_value != v}, 2'b11);
    $display("test counting done");
    apb(1'b1, TCNT_OFS_CONTROL, 8'h80);
    apb(1'b1, TCNT_OFS_HIGH, 8'h12);
    apb(1'b1, TCNT_OFS_LOW, 8'h34);
    apb(1'b1, TCNT_OFS_HIGH, 8'h77);
    chk(count_value, 16'h1234);
    apb(1'b0, TCNT_OFS_LOW, 8'h00);
    apb(1'b0, TCNT_OFS_HIGH, 8'h00);
    chk(rv, 8'h12);
    apb(1'b1, TCNT_OFS_CONTROL, 8'h00);
    apb(1'b1, TCNT_OFS_HIGH, 8'h56);
    chk(count_value, 16'h5634);
    $display("test wide done");
    apb(1'b1, TCNT_OFS_FLAG, 8'h02);
    apb(1'b1, TCNT_OFS_LOW, 8'hfe);
    apb(1'b1, TCNT_OFS_HIGH, 8'hff);
    apb(1'b1, TCNT_OFS_CONTROL, 8'h01);
    n = 0;
    while (overflow_irq !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    apb(1'b0, TCNT_OFS_FLAG, 8'h00);
    chk(rv, 8'h03);
    apb(1'b1, TCNT_OFS_FLAG, 8'h03);
    apb(1'b0, TCNT_OFS_FLAG, 8'h00);
    chk({rv, overflow_irq}, 9'h004);
    apb(1'b1, TCNT_OFS_CONTROL, 8'h00);
    apb(1'b1, TCNT_OFS_LOW, 8'h10);
    pulse_trig(4'ha);
    chk(count_value, 16'h0010);
    pulse_trig(TCNT_CMP_SPECIAL_EVENT);
    chk({count_value, overflow_irq}, 17'h0);
    apb(1'b0, TCNT_OFS_FLAG, 8'h00);
    chk(rv, 8'h02);
    $display("test overflow done");
    sysclk_is_timer_osc <= 1'b1;
    apb(1'b1, TCNT_OFS_CONTROL, 8'h00);
    apb(1'b0, TCNT_OFS_CONTROL, 8'h00);
    chk(rv, 8'h40);
    sysclk_is_timer_osc <= 1'b0;
    apb(1'b1, TCNT_OFS_CONTROL, 8'h40);
    apb(1'b0, TCNT_OFS_CONTROL, 8'h00);
    chk(rv, 8'h00);
    apb(1'b1, TCNT_OFS_OSC, 8'h81);
    chk({secondary_run_mode, idle_on_sleep_enable}, 2'b11);
    $display("test clock select done");
    complete_run;
  end
endmodule
bind tcnt_timer tcnt_timer_monitor #(.CNT_W(CNT_W)) u_tcnt_timer_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .port_pin_in(port_pin_in), .port_pin_out_data(port_pin_out_data),
  .port_pin_out(port_pin_out), .port_pin_oe_n(port_pin_oe_n),
  .port_read_data(port_read_data), .secondary_run_mode(secondary_run_mode),
  .special_event_trigger(special_event_trigger),
  .compare_mode_field(compare_mode_field), .overflow_irq(overflow_irq),
  .count_value(count_value));
